// ---- shared/rx_liu_pkg.sv ----
// Constants, register map and carrier types for the receive line interface control block.
// Notes on behaviour
// R01: Reserved bits of test and config registers are written zero and ignored.
// R02: Writing one to the reset bit restarts the line interface; bit self-clears.
// R03: Software resets the interface after changing attenuation or equalizer data.
// R04: With squelch on, slicer outputs stay zero while equalizer-valid is zero.
// R05: With gain force set, the gain amplifier takes the gain ceiling value.
// R06: Digital select picks the external inputs and clock, else bipolar inputs.
// R07: Attenuation code scales coefficients on load: none, -10, -20, -30 dB.
// R08: Software writes config bit 0 as one and bit 1 as zero.
// R09: Rate adapter error shows loss of lock to its reference clock.
// R10: Store limit bit updates only near empty (one) or near full (zero).
// R11: On store error, limit zero means overflow, one means underrun.
// R12: Zero-substitution flag latches on first B8ZS or HDB3 pattern, decoding or not.
// R13: Excess-zeros flag latches on 10 (E1), 16 (T1) or 8 (T1 substituted) zeros.
// R14: With zeros-into-count set, each excess-zeros event also adds to the count.
// R15: Violation reporting depends on line rate and substitution mode.
// R16: Violation flag latches and holds; each violation increments the count.
// R17: Equalizer-valid shows live signal valid and clock recovery locked.
// R18: Pre-equalizer bit reads one when the pre-equalizer is active.
// R19: Analog loss declared after level stays in detect range for 1 ms.
// R20: Receiver loss declared after 32 zeros in E1 or 100 zeros in T1.
// R21: Typical settings are config 0x41, receive config 0xB1, ceiling 0x1D.
// R22: Status reads have no side effect; flags clear only on expired hold.
package rx_liu_pkg;
   // Register word indices; the byte address is four times the index.
   localparam logic [7:0] IDX_TEST = 8'h1c;
   localparam logic [7:0] IDX_LIU_CFG = 8'h20;
   localparam logic [7:0] IDX_STATUS = 8'h21;
   localparam logic [7:0] IDX_LINE_CFG = 8'h30;
   localparam logic [7:0] IDX_GAIN_CEIL = 8'h31;
   localparam logic [7:0] IDX_VIOL_CNT = 8'h32;
   localparam logic [7:0] IDX_LOSS = 8'h33;
   // Reset values.
   localparam logic [1:0] CFG_FIXED = 2'h1;
   localparam logic [4:0] CFG_RESET = 5'h00;
   localparam logic [1:0] TEST_RESET = 2'h0;
   localparam logic [2:0] LINE_CFG_RESET = 3'h0;
   localparam logic [5:0] GAIN_CEIL_RESET = 6'h3f;
   // Zero-run thresholds in bit times.
   localparam logic [6:0] EXZ_E1 = 7'h0a;
   localparam logic [6:0] EXZ_T1 = 7'h10;
   localparam logic [6:0] EXZ_T1_ZS = 7'h08;
   localparam logic [6:0] LOS_E1 = 7'h20;
   localparam logic [6:0] LOS_T1 = 7'h64;
   // Analog loss time and its count of system clocks.
   localparam int ALOS_TIME_US = 1000;
   localparam int CLK_MHZ = 250;
   localparam int ALOS_CYCLES = ALOS_TIME_US * CLK_MHZ;
   // Coefficient scale per attenuation code, in 1/32 steps.
   localparam logic [5:0] BRIDGE_ATTEN_SEL_SCALE_0 = 6'h20;
   localparam logic [5:0] BRIDGE_ATTEN_SEL_SCALE_1 = 6'h0a;
   localparam logic [5:0] BRIDGE_ATTEN_SEL_SCALE_2 = 6'h03;
   localparam logic [5:0] BRIDGE_ATTEN_SEL_SCALE_3 = 6'h01;
   // B8ZS symbol pattern 000VB0VB, newest bit in bit 0.
   localparam logic [7:0] B8ZS_MARKS = 8'h1b;
   localparam logic [7:0] B8ZS_VIOLS = 8'h12;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Interface configuration layout, bit 7 first.
   typedef struct packed {
      logic reset_cmd;
      logic squelch;
      logic force_gain;
      logic digital_input_select;
      logic [1:0] bridge_atten_sel;
      logic [1:0] fixed;
   } liu_cfg_t;
   // Receive status layout, bit 7 first.
   typedef struct packed {
      logic rate_adapter_lock_err;
      logic jitter_store_limit;
      logic zero_sub_seen;
      logic excess_zeros_flag;
      logic bipolar_violation_flag;
      logic rsvd;
      logic eq_valid;
      logic preequalizer_on;
   } rx_status_t;
   // Line coding options.
   typedef struct packed {
      logic zeros_into_count;
      logic rx_zero_sub_sel;
      logic line_rate_sel;
   } line_cfg_t;
endpackage : rx_liu_pkg

// ---- src/rx_line_iface_ctrl_status.sv ----
// Receive line interface control, line-code monitoring and status with an AXI4-Lite slave.
`timescale 1ns/100ps
module rx_line_iface_ctrl_status
   import rx_liu_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int ALOS_CNT = ALOS_CYCLES
)
(
   input wire logic clk_sys, // System clock.
   input wire logic rstn, // Synchronous reset, active low.
   input wire logic ce, // Clock enable; state freezes while low.
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic rx_bipolar_pos, // Sliced positive mark from the analog receiver.
   input wire logic rx_bipolar_neg, // Sliced negative mark from the analog receiver.
   input wire logic rx_recovered_bit_en, // Bit strobe from internal clock recovery.
   input wire logic rx_pos_digital_in, // External positive rail.
   input wire logic rx_neg_digital_in, // External negative rail.
   input wire logic rx_clock_digital_in, // External line clock, sampled.
   input wire logic eq_valid_in, // Equalizer open and recovery loop locked.
   input wire logic preequalizer_on_in, // Pre-equalizer active.
   input wire logic rate_adapter_lock_err_in, // Rate adapter phase detector out of lock.
   input wire logic store_near_empty_in, // Elastic store within two bits of empty.
   input wire logic store_near_full_in, // Elastic store within two bits of full.
   input wire logic level_in_range_in, // Receive level inside loss detect range.
   input wire logic err_hold_expire_in, // Error hold interval has ended.
   input wire logic [5:0] vga_adapt_gain_in, // Gain chosen by automatic control.
   input wire logic [7:0] rom_coef_in, // Equalizer coefficient from ROM.
   input wire logic rom_coef_valid_in, // Coefficient strobe.
   output logic slicer_pos_ff, // Positive data to the receiver.
   output logic slicer_neg_ff, // Negative data to the receiver.
   output logic slicer_bit_en_ff, // Bit strobe for the slicer data.
   output logic [5:0] vga_gain_ff, // Gain applied to the amplifier.
   output logic iface_reset_ff, // One-cycle interface reset pulse.
   output logic [7:0] coef_scaled_ff, // Coefficient after bridge scaling.
   output logic coef_valid_ff, // Scaled coefficient strobe.
   output logic [1:0] test_mode_ff, // Production test enable bits.
   output logic analog_signal_loss_ff, // Analog loss of signal.
   output logic rx_signal_loss_ff // Receiver loss of signal.
);
   localparam int ALOS_W = $clog2(ALOS_CNT + 1);
   localparam logic [ALOS_W-1:0] ALOS_LAST = ALOS_W'(ALOS_CNT - 1);

   liu_cfg_t cfg_ff;
   line_cfg_t lcfg_ff;
   logic [5:0] gain_ceil_ff;
   logic [15:0] viol_cnt_ff;
   logic aw_held_ff, w_held_ff, rck_prev_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic have_mark_ff, last_neg_ff, have_viol_ff, last_viol_neg_ff, store_limit_ff;
   logic [7:0] mark_h_ff, viol_h_ff, pend_h_ff;
   logic [6:0] zrun_ff;
   logic [2:0] flags_ff;
   logic [ALOS_W-1:0] alos_cnt_ff;

   // Write decode; byte address is the index shifted up by two.
   wire [ADDR_W-3:0] wr_idx = awaddr_ff[ADDR_W-1:2];
   wire [ADDR_W-3:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
   wire do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
   wire wr_lane = do_write && wstrb_ff[0];
   wire wr_test = wr_idx == (ADDR_W-2)'(IDX_TEST);
   wire wr_cfg = wr_idx == (ADDR_W-2)'(IDX_LIU_CFG);
   wire wr_lcfg = wr_idx == (ADDR_W-2)'(IDX_LINE_CFG);
   wire wr_gain = wr_idx == (ADDR_W-2)'(IDX_GAIN_CEIL);
   wire wr_ro = wr_idx == (ADDR_W-2)'(IDX_STATUS) || wr_idx == (ADDR_W-2)'(IDX_VIOL_CNT)
                || wr_idx == (ADDR_W-2)'(IDX_LOSS);
   wire wr_hit = wr_test || wr_cfg || wr_lcfg || wr_gain || wr_ro;
   wire nxt_aw_held = (s_axi_awvalid && s_axi_awready) || (aw_held_ff && !do_write);
   wire nxt_w_held = (s_axi_wvalid && s_axi_wready) || (w_held_ff && !do_write);
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire nxt_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
   wire s_axi_wdata_held7 = wdata_ff[7];
   wire nxt_iface_reset = wr_lane && wr_cfg && s_axi_wdata_held7; // R02

   // Status word; reading it changes nothing.
   rx_status_t status;
   assign status = '{rate_adapter_lock_err: rate_adapter_lock_err_in, // R09
                     jitter_store_limit: store_limit_ff, // R11
                     zero_sub_seen: flags_ff[2],
                     excess_zeros_flag: flags_ff[1],
                     bipolar_violation_flag: flags_ff[0],
                     rsvd: 1'b0,
                     eq_valid: eq_valid_in, // R17
                     preequalizer_on: preequalizer_on_in}; // R18

   // Read decode; unmapped words read zero with an error response.
   logic [31:0] rd_data;
   logic rd_hit;
   always_comb
   begin
      rd_hit = 1'b1;
      unique case (rd_idx)
         (ADDR_W-2)'(IDX_TEST): rd_data = {30'h0, test_mode_ff}; // R01
         (ADDR_W-2)'(IDX_LIU_CFG): rd_data = {24'h0, 1'b0, cfg_ff[6:2], CFG_FIXED}; // R08
         (ADDR_W-2)'(IDX_STATUS): rd_data = {24'h0, status}; // R22
         (ADDR_W-2)'(IDX_LINE_CFG): rd_data = {29'h0, lcfg_ff};
         (ADDR_W-2)'(IDX_GAIN_CEIL): rd_data = {26'h0, gain_ceil_ff};
         (ADDR_W-2)'(IDX_VIOL_CNT): rd_data = {16'h0, viol_cnt_ff};
         (ADDR_W-2)'(IDX_LOSS): rd_data = {30'h0, analog_signal_loss_ff, rx_signal_loss_ff};
         default:
         begin
            rd_data = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Bus handshakes. Address and data are held until both are present.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         {aw_held_ff, w_held_ff, s_axi_bvalid, s_axi_rvalid} <= 4'h0;
         {s_axi_awready, s_axi_wready, s_axi_arready} <= 3'h7;
         {s_axi_bresp, s_axi_rresp} <= 4'h0;
         s_axi_rdata <= 32'h0;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end
      else if (ce)
      begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         s_axi_awready <= !nxt_aw_held;
         s_axi_wready <= !nxt_w_held;
         if (s_axi_awvalid && s_axi_awready)
            awaddr_ff <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         s_axi_bvalid <= do_write || (s_axi_bvalid && !s_axi_bready);
         if (do_write)
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         s_axi_rvalid <= nxt_rvalid;
         s_axi_arready <= !nxt_rvalid;
         if (ar_take)
         begin
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Writable registers; only defined bits are kept, the reset bit is never stored.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         cfg_ff <= '{fixed: CFG_FIXED, default: 1'b0};
         test_mode_ff <= TEST_RESET;
         lcfg_ff <= LINE_CFG_RESET;
         gain_ceil_ff <= GAIN_CEIL_RESET;
         iface_reset_ff <= 1'b0;
      end
      else if (ce)
      begin
         iface_reset_ff <= nxt_iface_reset; // R02
         if (wr_lane && wr_cfg)
            cfg_ff[6:2] <= wdata_ff[6:2]; // R01
         if (wr_lane && wr_test)
            test_mode_ff <= wdata_ff[1:0]; // R01
         if (wr_lane && wr_lcfg)
            lcfg_ff <= wdata_ff[2:0];
         if (wr_lane && wr_gain)
            gain_ceil_ff <= wdata_ff[5:0];
      end
   end

   // Input selection: external rails and clock edge, or analog slicer and recovered strobe.
   wire digi = cfg_ff.digital_input_select;
   wire bit_en = digi ? (rx_clock_digital_in && !rck_prev_ff) : rx_recovered_bit_en; // R06
   wire sel_pos = digi ? rx_pos_digital_in : rx_bipolar_pos; // R06
   wire sel_neg = (digi ? rx_neg_digital_in : rx_bipolar_neg) && !sel_pos;
   wire squelch_on = cfg_ff.squelch && !eq_valid_in; // R04

   // Slicer outputs, gain and coefficient scaling.
   logic [5:0] atten_scale;
   always_comb
   begin
      unique case (cfg_ff.bridge_atten_sel)
         2'h0: atten_scale = BRIDGE_ATTEN_SEL_SCALE_0;
         2'h1: atten_scale = BRIDGE_ATTEN_SEL_SCALE_1;
         2'h2: atten_scale = BRIDGE_ATTEN_SEL_SCALE_2;
         2'h3: atten_scale = BRIDGE_ATTEN_SEL_SCALE_3;
      endcase
   end
   wire [13:0] coef_prod = rom_coef_in * atten_scale; // R07

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         {slicer_pos_ff, slicer_neg_ff, slicer_bit_en_ff, rck_prev_ff} <= 4'h0;
         vga_gain_ff <= 6'h00;
         coef_scaled_ff <= 8'h00;
         coef_valid_ff <= 1'b0;
      end
      else if (ce)
      begin
         rck_prev_ff <= rx_clock_digital_in;
         slicer_pos_ff <= sel_pos && !squelch_on; // R04
         slicer_neg_ff <= sel_neg && !squelch_on; // R04
         slicer_bit_en_ff <= bit_en;
         vga_gain_ff <= cfg_ff.force_gain ? gain_ceil_ff : vga_adapt_gain_in; // R05
         coef_scaled_ff <= coef_prod[12:5]; // R07
         coef_valid_ff <= rom_coef_valid_in;
      end
   end

   // Line-code detection on the selected symbol stream.
   wire t1 = lcfg_ff.line_rate_sel;
   wire zs = lcfg_ff.rx_zero_sub_sel;
   wire mark = sel_pos || sel_neg;
   wire viol = mark && have_mark_ff && (sel_neg == last_neg_ff);
   wire [6:0] zrun_inc = (zrun_ff == 7'h7f) ? zrun_ff : zrun_ff + 7'h01;
   wire [6:0] exz_thr = t1 ? (zs ? EXZ_T1_ZS : EXZ_T1) : EXZ_E1; // R13
   wire [6:0] los_thr = t1 ? LOS_T1 : LOS_E1; // R20
   wire [7:0] mark_h_nxt = {mark_h_ff[6:0], mark};
   wire [7:0] viol_h_nxt = {viol_h_ff[6:0], viol};
   wire b8zs_hit = mark_h_nxt == B8ZS_MARKS && viol_h_nxt == B8ZS_VIOLS;
   wire hdb3_hit = viol && !mark_h_ff[0] && !mark_h_ff[1] && !viol_h_ff[2];
   wire zsub_ev = bit_en && (t1 ? b8zs_hit : hdb3_hit); // R12
   wire exz_ev = bit_en && !mark && zrun_inc == exz_thr; // R13
   // T1 substituted violations wait eight bits so a whole B8ZS code can excuse them.
   wire [7:0] pend_nxt = {pend_h_ff[6:0], viol} & ~(b8zs_hit ? B8ZS_VIOLS : 8'h00);
   wire e1_pair = viol && have_viol_ff && (sel_neg == last_viol_neg_ff);
   wire bpv_sel = !zs ? viol : (t1 ? pend_h_ff[7] : e1_pair); // R15
   wire bpv_ev = bit_en && bpv_sel;
   wire [1:0] cnt_add = {1'b0, bpv_ev} + {1'b0, exz_ev && lcfg_ff.zeros_into_count}; // R14
   wire [16:0] cnt_sum = {1'b0, viol_cnt_ff} + {15'h0, cnt_add};

   always_ff @(posedge clk_sys)
   begin
      if (!rstn || iface_reset_ff)
      begin
         {have_mark_ff, last_neg_ff, have_viol_ff, last_viol_neg_ff} <= 4'h0;
         {mark_h_ff, viol_h_ff, pend_h_ff} <= 24'h0;
         zrun_ff <= 7'h00;
         rx_signal_loss_ff <= 1'b0;
      end
      else if (ce && bit_en)
      begin
         have_mark_ff <= have_mark_ff || mark;
         if (mark)
            last_neg_ff <= sel_neg;
         if (viol)
         begin
            have_viol_ff <= 1'b1;
            last_viol_neg_ff <= sel_neg;
         end
         mark_h_ff <= mark_h_nxt;
         viol_h_ff <= viol_h_nxt;
         pend_h_ff <= pend_nxt;
         zrun_ff <= mark ? 7'h00 : zrun_inc;
         rx_signal_loss_ff <= !mark && zrun_inc >= los_thr; // R20
      end
   end

   // Sticky flags: a new event beats the hold expiry in the same cycle.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         flags_ff <= 3'h0;
         viol_cnt_ff <= 16'h0000;
         store_limit_ff <= 1'b0;
      end
      else if (ce)
      begin
         flags_ff <= {zsub_ev, exz_ev, bpv_ev} | (flags_ff & ~{3{err_hold_expire_in}}); // R22
         viol_cnt_ff <= cnt_sum[16] ? 16'hffff : cnt_sum[15:0]; // R16
         if (store_near_empty_in)
            store_limit_ff <= 1'b1; // R10
         else if (store_near_full_in)
            store_limit_ff <= 1'b0; // R10
      end
   end

   // Analog loss: level must stay in range for the full count without a break.
   always_ff @(posedge clk_sys)
   begin
      if (!rstn || iface_reset_ff)
      begin
         alos_cnt_ff <= '0;
         analog_signal_loss_ff <= 1'b0;
      end
      else if (ce)
      begin
         if (!level_in_range_in)
            alos_cnt_ff <= '0;
         else if (alos_cnt_ff != ALOS_LAST)
            alos_cnt_ff <= alos_cnt_ff + ALOS_W'(1);
         analog_signal_loss_ff <= level_in_range_in && alos_cnt_ff == ALOS_LAST; // R19
      end
   end

   // Checks on the logic above.
   a_reset_self_clears: assert property (@(posedge clk_sys) disable iff (!rstn) // R02
      (ce && iface_reset_ff) |=> !iface_reset_ff && cfg_ff.reset_cmd == 1'b0)
      else $error("Interface reset did not clear itself.");
   a_squelch_holds_zero: assert property (@(posedge clk_sys) disable iff (!rstn) // R04
      (ce && cfg_ff.squelch && !eq_valid_in) |=> !slicer_pos_ff && !slicer_neg_ff)
      else $error("Slicer output not squelched.");
   a_gain_forced: assert property (@(posedge clk_sys) disable iff (!rstn) // R05
      (ce && cfg_ff.force_gain) |=> vga_gain_ff == $past(gain_ceil_ff))
      else $error("Forced gain differs from ceiling.");
   a_digital_path_used: assert property (@(posedge clk_sys) disable iff (!rstn) // R06
      (ce && digi && !squelch_on) |=> slicer_pos_ff == $past(rx_pos_digital_in))
      else $error("Digital input not selected.");
   a_atten_none_passes: assert property (@(posedge clk_sys) disable iff (!rstn) // R07
      (ce && cfg_ff.bridge_atten_sel == 2'h0) |=> coef_scaled_ff == $past(rom_coef_in))
      else $error("Unattenuated coefficient altered.");
   a_limit_holds: assert property (@(posedge clk_sys) disable iff (!rstn) // R10
      (ce && !store_near_empty_in && !store_near_full_in) |=> $stable(store_limit_ff))
      else $error("Store limit changed away from a limit.");
   a_violation_counted: assert property (@(posedge clk_sys) disable iff (!rstn) // R16
      (ce && bpv_ev && !exz_ev && viol_cnt_ff != 16'hffff)
      |=> viol_cnt_ff == $past(viol_cnt_ff) + 16'h0001 && flags_ff[0])
      else $error("Violation not counted or flagged.");
   a_flag_set_wins: assert property (@(posedge clk_sys) disable iff (!rstn) // R22
      (ce && err_hold_expire_in && exz_ev) |=> flags_ff[1])
      else $error("Excess-zeros event lost on hold expiry.");
   a_alos_declared: assert property (@(posedge clk_sys) disable iff (!rstn) // R19
      (ce && !iface_reset_ff && level_in_range_in && alos_cnt_ff == ALOS_LAST)
      |=> analog_signal_loss_ff)
      else $error("Analog loss not declared after full count.");
endmodule : rx_line_iface_ctrl_status

// ---- testbench/rx_line_model.sv ----
// Behavioural receive line that feeds marks and bit strobes to the block.
`timescale 1ns/100ps
module rx_line_model
(
   input wire logic clk_sys, // System clock.
   output logic pos, // Positive mark.
   output logic neg, // Negative mark.
   output logic bit_en // Recovered bit strobe.
);
   // Quiet line at time zero.
   initial
   begin
      pos = 1'b0;
      neg = 1'b0;
      bit_en = 1'b0;
   end
   // One bit per call; the rails then show the inverse so stale data never passes as a bit.
   task automatic send(input logic p, input logic n);
      @(posedge clk_sys);
      pos <= p;
      neg <= n;
      bit_en <= 1'b1;
      @(posedge clk_sys);
      pos <= ~p;
      neg <= ~n;
      bit_en <= 1'b0;
   endtask : send
endmodule : rx_line_model

// ---- testbench/tb_top.sv ----
// Self-checking bench for the receive line interface control and status block.
`timescale 1ns/100ps
module tb_top;
   import rx_liu_pkg::*;
   logic clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, test_mode_ff;
   logic s_axi_rvalid, rx_bipolar_pos, rx_bipolar_neg, rx_recovered_bit_en;
   logic rx_pos_digital_in = 0, rx_neg_digital_in = 0, rx_clock_digital_in = 0;
   logic eq_valid_in = 0, preequalizer_on_in = 0, rate_adapter_lock_err_in = 0;
   logic store_near_empty_in = 0, store_near_full_in = 0, level_in_range_in = 0;
   logic err_hold_expire_in = 0, rom_coef_valid_in = 0;
   logic [5:0] vga_adapt_gain_in = 6'h0b, vga_gain_ff;
   logic [7:0] rom_coef_in = 8'h40, coef_scaled_ff;
   logic slicer_pos_ff, slicer_neg_ff, slicer_bit_en_ff, iface_reset_ff, coef_valid_ff;
   logic analog_signal_loss_ff, rx_signal_loss_ff;
   int errors = 0, comparisons = 0, pulses = 0, k;
   localparam logic [7:0] SCALED [4] = '{8'h40, 8'h14, 8'h06, 8'h02};
   // Clock and a count of interface reset pulses, which are too short to catch in a task.
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (iface_reset_ff === 1'b1) pulses <= pulses + 1;
   rx_line_model line_u (.clk_sys, .pos(rx_bipolar_pos), .neg(rx_bipolar_neg),
      .bit_en(rx_recovered_bit_en));
   rx_line_iface_ctrl_status #(.ADDR_W(12), .ALOS_CNT(16)) dut_u (.clk_sys, .rstn, .ce,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_bipolar_pos,
      .rx_bipolar_neg, .rx_recovered_bit_en, .rx_pos_digital_in, .rx_neg_digital_in,
      .rx_clock_digital_in, .eq_valid_in, .preequalizer_on_in, .rate_adapter_lock_err_in,
      .store_near_empty_in, .store_near_full_in, .level_in_range_in, .err_hold_expire_in,
      .vga_adapt_gain_in, .rom_coef_in, .rom_coef_valid_in, .slicer_pos_ff, .slicer_neg_ff,
      .slicer_bit_en_ff, .vga_gain_ff, .iface_reset_ff, .coef_scaled_ff, .coef_valid_ff,
      .test_mode_ff, .analog_signal_loss_ff, .rx_signal_loss_ff);
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // One edge of a bounded wait; a hang is counted and closes the run.
   task automatic tick(inout int n);
      @(posedge clk_sys);
      n++;
      if (n > 200)
      begin
         errors++;
         end_of_test();
      end
   endtask : tick
   // Each channel is held until its own ready; the response is awaited with bready up.
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         tick(n);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [11:0] a);
      int n = 0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         tick(n);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask : axr
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      axr(a);
      chk(rd, exp);
   endtask : rchk
   // Main sequence; inputs change by non-blocking assignment at rising edges.
   initial
   begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      rchk(12'h080, 32'h01);
      rchk(12'h0c4, 32'h3f);
      axw(12'h070, 32'hff);
      rchk(12'h070, 32'h03);
      chk(test_mode_ff, 2'h3);
      axr(12'h100);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      chk(rd, 32'h0);
      $display("Register test done");
      @(posedge clk_sys);
      {eq_valid_in, preequalizer_on_in, rate_adapter_lock_err_in} <= 3'h7;
      store_near_empty_in <= 1'b1;
      rchk(12'h084, 32'hc3);
      store_near_empty_in <= 1'b0;
      store_near_full_in <= 1'b1;
      rchk(12'h084, 32'h83);
      store_near_full_in <= 1'b0;
      rchk(12'h084, 32'h83);
      {eq_valid_in, preequalizer_on_in, rate_adapter_lock_err_in} <= 3'h0;
      rchk(12'h084, 32'h00);
      $display("Status test done");
      axw(12'h080, 32'h41);
      line_u.send(1'b1, 1'b0);
      #1 chk(slicer_pos_ff, 1'b0);
      @(posedge clk_sys);
      eq_valid_in <= 1'b1;
      line_u.send(1'b1, 1'b0);
      #1 chk(slicer_pos_ff, 1'b1);
      axw(12'h0c0, 32'h04);
      repeat (32) line_u.send(1'b0, 1'b0);
      #1 chk(rx_signal_loss_ff, 1'b1);
      line_u.send(1'b0, 1'b1);
      #1 chk(rx_signal_loss_ff, 1'b0);
      line_u.send(1'b0, 1'b1);
      rchk(12'h084, 32'h1a);
      rchk(12'h0c8, 32'h03);
      rchk(12'h084, 32'h1a);
      err_hold_expire_in <= 1'b1;
      @(posedge clk_sys);
      err_hold_expire_in <= 1'b0;
      rchk(12'h084, 32'h02);
      // Three zeros then a same-polarity mark form a substitution code in E1.
      repeat (3) line_u.send(1'b0, 1'b0);
      line_u.send(1'b0, 1'b1);
      rchk(12'h084, 32'h2a);
      rchk(12'h0c8, 32'h04);
      $display("Line test done");
      axw(12'h0c4, 32'h1d);
      axw(12'h080, 32'h61);
      repeat (2) @(posedge clk_sys);
      #1 chk(vga_gain_ff, 6'h1d);
      for (k = 0; k < 4; k++)
      begin
         axw(12'h080, 32'h41 | (k << 2));
         axw(12'h080, 32'hc1 | (k << 2));
         rchk(12'h080, 32'h41 | (k << 2));
         chk(vga_gain_ff, 6'h0b);
         @(posedge clk_sys);
         rom_coef_valid_in <= 1'b1;
         @(posedge clk_sys);
         rom_coef_valid_in <= 1'b0;
         #1 chk({coef_valid_ff, coef_scaled_ff}, {1'b1, SCALED[k]});
      end
      chk(pulses, 4);
      // External rails and clock edge; the bipolar rails still show a positive mark.
      axw(12'h080, 32'h11);
      @(posedge clk_sys);
      {rx_neg_digital_in, rx_clock_digital_in} <= 2'h3;
      @(posedge clk_sys);
      rx_clock_digital_in <= 1'b0;
      #1 chk({slicer_bit_en_ff, slicer_pos_ff, slicer_neg_ff}, 3'h5);
      @(posedge clk_sys);
      #1 chk({slicer_bit_en_ff, slicer_pos_ff, slicer_neg_ff}, 3'h1);
      @(posedge clk_sys);
      level_in_range_in <= 1'b1;
      repeat (10) @(posedge clk_sys);
      #1 chk(analog_signal_loss_ff, 1'b0);
      repeat (10) @(posedge clk_sys);
      #1 chk(analog_signal_loss_ff, 1'b1);
      // With the clock enable low the loss flag must stay frozen.
      @(posedge clk_sys);
      {ce, level_in_range_in} <= 2'h0;
      repeat (2) @(posedge clk_sys);
      #1 chk(analog_signal_loss_ff, 1'b1);
      $display("Config test done");
      end_of_test();
   end
endmodule : tb_top
